// ==== rtl/cspo_regs.sv ====
// status and option register bank with counter prescaler and config word store
`timescale 1ns/10ps
`include "cspo_defs.svh"

// Notes on behaviour
// - status at 03h is read/write, watchdog-timeout and power-down bits ignore writes
// - alu flags from the writing instruction override written flag bits
// - bits 7:5 select program page 0..7, each 200h words
// - timeout flag set at power-up, watchdog-clear, sleep; cleared on watchdog time-out
// - power-down flag set at power-up and watchdog-clear; cleared by sleep
// - zero flag is one when the arithmetic result is zero
// - digit carry is carry out of bit 3, or no-borrow on subtract
// - carry is carry out of bit 7, or no-borrow on subtract
// - rotate right loads carry with lsb, rotate left with msb
// - carry-input option cleared feeds carry flag into add and subtract
// - extended-option primary_config_word set makes option bits 7 and 6 read one and inert
// - option bit 7 maps address 01h to working register or counter
// - option bit 6 low enables counter rollover interrupt
// - counter counts instruction cycles or external pin transitions
// - external source counts rising edges when zero, falling when one
// - prescaler serves counter when assign bit zero, else watchdog with counter 1:1
// - ratio n divides counter by 2^(n+1), watchdog by 2^n
// - every reset sets all option bits to one
// - config words change only in programming mode; identity register is read-only
// - 12-bit config word lives at FFFh, bits 11 down to 0
module cspo_regs
    import cspo_pkg::*;
#(
    parameter int PC_LOW_W = 9,
    parameter logic [7:0] DEVICE_ID = 8'h5a  // arbitrary value
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic por_i,
    input wire logic file_wr_i,
    input wire logic [4:0] file_addr_i,
    input wire logic [7:0] file_wdata_i,
    input wire logic opt_wr_i,
    input wire logic [7:0] opt_wdata_i,
    input wire logic [2:0] alu_op_i,
    input wire logic [7:0] alu_a_i,
    input wire logic [7:0] alu_b_i,
    input wire logic wdt_clear_i,
    input wire logic sleep_i,
    input wire logic wdt_timeout_i,
    input wire logic jump_i,
    input wire logic [PC_LOW_W-1:0] jump_low_i,
    input wire logic counter_pin_i,
    input wire logic prog_mode_i,
    input wire logic cfg_wr_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [11:0] cfg_wdata_i,
    output logic [7:0] status_o,
    output logic [7:0] option_o,
    output logic [7:0] alu_result_o,
    output logic [7:0] free_running_counter_o,
    output logic addr01_is_counter_o,
    output logic rollover_irq_o,
    output logic wdt_tick_o,
    output logic [PC_LOW_W+2:0] jump_target_o,
    output logic [11:0] cfg_rdata_o,
    output logic [7:0] device_id_o
);

    // ------------------------------------------------------------
    // config word store
    // ------------------------------------------------------------
    logic [11:0] primary_config_word;
    logic extended_config_primary_config_word;
    logic carry_input_option;

    assign extended_config_primary_config_word = primary_config_word[`CSPO_CFG_XOPT_BIT];
    assign carry_input_option = primary_config_word[`CSPO_CFG_CARRY_BIT];

    // only programming mode may touch the word; normal run leaves it frozen
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            primary_config_word <= `CSPO_CFG_RESET;
        end else if (ce_i && prog_mode_i && cfg_wr_i && cfg_addr_i == `CSPO_CFG_ADDR) begin
            primary_config_word <= cfg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_rdata_o <= 12'h000;
            device_id_o <= 8'h00;
        end else if (ce_i) begin
            device_id_o <= DEVICE_ID;
            if (prog_mode_i && cfg_addr_i == `CSPO_CFG_ADDR) begin
                cfg_rdata_o <= primary_config_word;
            end else begin
                cfg_rdata_o <= 12'h000;
            end
        end
    end

    // ------------------------------------------------------------
    // alu flag computation
    // ------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] alu_res;
    logic flag_c, flag_dc, flag_z, upd_c, upd_dc, upd_z, cin;
    logic [8:0] sum9;
    logic [4:0] sum5;

    always_comb begin
        // with the option cleared the stored carry joins the operation
        cin = carry_input_option ? 1'b0 : status[`CSPO_C_BIT];
        sum9 = 9'h000;
        sum5 = 5'h00;
        alu_res = alu_a_i;
        flag_c = status[`CSPO_C_BIT];
        flag_dc = status[`CSPO_DC_BIT];
        upd_c = 1'b0;
        upd_dc = 1'b0;
        upd_z = 1'b0;
        case (cspo_alu_op_type'(alu_op_i))
            cspo_op_add: begin
                sum9 = {1'b0, alu_a_i} + {1'b0, alu_b_i} + {8'h00, cin};
                sum5 = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]} + {4'h0, cin};
                alu_res = sum9[7:0];
                flag_c = sum9[8];
                flag_dc = sum5[4];
                {upd_c, upd_dc, upd_z} = 3'b111;
            end
            cspo_op_sub: begin
                // carry set means no borrow; with the option cleared an incoming clear carry acts as a borrow
                sum9 = {1'b0, alu_a_i} + {1'b0, ~alu_b_i}
                    + {8'h00, carry_input_option | status[`CSPO_C_BIT]};
                sum5 = {1'b0, alu_a_i[3:0]} + {1'b0, ~alu_b_i[3:0]}
                    + {4'h0, carry_input_option | status[`CSPO_C_BIT]};
                alu_res = sum9[7:0];
                flag_c = sum9[8];
                flag_dc = sum5[4];
                {upd_c, upd_dc, upd_z} = 3'b111;
            end
            cspo_op_rr: begin
                alu_res = {status[`CSPO_C_BIT], alu_a_i[7:1]};
                flag_c = alu_a_i[0];
                upd_c = 1'b1;
            end
            cspo_op_rl: begin
                alu_res = {alu_a_i[6:0], status[`CSPO_C_BIT]};
                flag_c = alu_a_i[7];
                upd_c = 1'b1;
            end
            cspo_op_logic: begin
                alu_res = alu_a_i & alu_b_i;
                upd_z = 1'b1;
            end
            default: begin
                alu_res = alu_a_i;
            end
        endcase
        flag_z = (alu_res == 8'h00);
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alu_result_o <= 8'h00;
        end else if (ce_i) begin
            alu_result_o <= alu_res;
        end
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    logic status_wr;
    logic [2:0] page_sel;
    logic [2:0] arith_flags;
    logic watchdog_timeout_flag;
    logic power_down_flag;
    assign status_wr = file_wr_i && file_addr_i == `CSPO_STATUS_ADDR;
    // each part has its own process, so no bit of the status byte has two drivers
    assign status = {page_sel, watchdog_timeout_flag, power_down_flag, arith_flags};

    // page and arithmetic bits: written byte first, then the flags of the same
    // instruction land on top, so a full-byte write may not stick
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            page_sel <= `CSPO_PAGE_RESET;
            arith_flags <= `CSPO_FLAGS_RESET;
        end else if (ce_i) begin
            if (status_wr) begin
                page_sel <= file_wdata_i[`CSPO_PAGE_HI:`CSPO_PAGE_LO];
                arith_flags <= file_wdata_i[`CSPO_Z_BIT:`CSPO_C_BIT];
            end
            if (upd_z) arith_flags[`CSPO_Z_BIT] <= flag_z;
            if (upd_dc) arith_flags[`CSPO_DC_BIT] <= flag_dc;
            if (upd_c) arith_flags[`CSPO_C_BIT] <= flag_c;
        end
    end

    // reset state flags: software writes never reach them
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            watchdog_timeout_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end else if (ce_i) begin
            if (por_i || wdt_clear_i || sleep_i) begin
                watchdog_timeout_flag <= 1'b1;
            end else if (wdt_timeout_i) begin
                watchdog_timeout_flag <= 1'b0;
            end
            if (por_i || wdt_clear_i) begin
                power_down_flag <= 1'b1;
            end else if (sleep_i) begin
                power_down_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_o <= `CSPO_STATUS_RESET;
        end else if (ce_i) begin
            status_o <= status;
        end
    end

    // ------------------------------------------------------------
    // page concatenation for jump and call
    // ------------------------------------------------------------
    // all three page bits go up; pages above 3 are left to the memory decode
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            jump_target_o <= '0;
        end else if (ce_i && jump_i) begin
            jump_target_o <= {status[`CSPO_PAGE_HI:`CSPO_PAGE_LO], jump_low_i};
        end
    end

    // ------------------------------------------------------------
    // option register
    // ------------------------------------------------------------
    logic [7:0] option;
    logic [7:0] option_eff;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            option <= `CSPO_OPT_RESET;
        end else if (ce_i) begin
            if (por_i) begin
                option <= `CSPO_OPT_RESET;
            end else if (opt_wr_i) begin
                option <= opt_wdata_i;
            end
        end
    end

    always_comb begin
        option_eff = option;
        if (extended_config_primary_config_word) begin
            option_eff[`CSPO_OPT_ADDR01] = 1'b1;
            option_eff[`CSPO_OPT_RIRQ] = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            option_o <= `CSPO_OPT_RESET;
            addr01_is_counter_o <= 1'b1;
        end else if (ce_i) begin
            option_o <= option_eff;
            addr01_is_counter_o <= option_eff[`CSPO_OPT_ADDR01];
        end
    end

    // ------------------------------------------------------------
    // counter source, prescaler and counter
    // ------------------------------------------------------------
    logic pin_meta, pin_sync, pin_prev;
    logic ext_edge, src_tick, cnt_tick;
    logic [7:0] prescale;
    logic [7:0] ps_mask;
    logic [7:0] counter;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else if (ce_i) begin
            pin_meta <= counter_pin_i;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign ext_edge = option[`CSPO_OPT_EDGE] ? (pin_prev && !pin_sync)
                                             : (!pin_prev && pin_sync);
    assign src_tick = option[`CSPO_OPT_SRC] ? ext_edge : 1'b1;

    // mask of 2^(n+1)-1 for the counter, 2^n-1 for the watchdog
    always_comb begin
        ps_mask = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (option[`CSPO_OPT_PSA]) begin
                ps_mask[i] = (i < int'(option[`CSPO_OPT_PS_HI:0]));
            end else begin
                ps_mask[i] = (i <= int'(option[`CSPO_OPT_PS_HI:0]));
            end
        end
    end

    always_comb begin
        if (option[`CSPO_OPT_PSA]) begin
            cnt_tick = src_tick;
        end else begin
            cnt_tick = src_tick && ((prescale & ps_mask) == ps_mask);
        end
    end

    // the prescaler counts counter source ticks, or every cycle for the watchdog
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prescale <= 8'h00;
        end else if (ce_i) begin
            if (opt_wr_i || wdt_clear_i) begin
                prescale <= 8'h00;
            end else if (option[`CSPO_OPT_PSA] || src_tick) begin
                prescale <= prescale + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            counter <= 8'h00;
        end else if (ce_i) begin
            if (file_wr_i && file_addr_i == `CSPO_ADDR01 && option_eff[`CSPO_OPT_ADDR01]) begin
                counter <= file_wdata_i;
            end else if (cnt_tick) begin
                counter <= counter + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            free_running_counter_o <= 8'h00;
            rollover_irq_o <= 1'b0;
            wdt_tick_o <= 1'b0;
        end else if (ce_i) begin
            free_running_counter_o <= counter;
            rollover_irq_o <= cnt_tick && counter == 8'hff
                && !option_eff[`CSPO_OPT_RIRQ];
            wdt_tick_o <= option[`CSPO_OPT_PSA] ? ((prescale & ps_mask) == ps_mask) : 1'b1;
        end
    end

endmodule // cspo_regs

// ==== include/cspo_defs.svh ====
// register offsets, field positions, reset values and widths of the status/option bank
`ifndef CSPO_DEFS_SVH
`define CSPO_DEFS_SVH
`define CSPO_STATUS_ADDR 5'h03
`define CSPO_ADDR01 5'h01
`define CSPO_CFG_ADDR 12'hfff
`define CSPO_PAGE_HI 7
`define CSPO_PAGE_LO 5
`define CSPO_TO_BIT 4
`define CSPO_PD_BIT 3
`define CSPO_Z_BIT 2
`define CSPO_DC_BIT 1
`define CSPO_C_BIT 0
`define CSPO_OPT_ADDR01 7
`define CSPO_OPT_RIRQ 6
`define CSPO_OPT_SRC 5
`define CSPO_OPT_EDGE 4
`define CSPO_OPT_PSA 3
`define CSPO_OPT_PS_HI 2
`define CSPO_OPT_RESET 8'hff
`define CSPO_STATUS_RESET 8'h18
`define CSPO_PAGE_RESET 3'h0
`define CSPO_FLAGS_RESET 3'h0
`define CSPO_PAGE_MAX 3'h3
`define CSPO_CFG_RESET 12'hfff
`define CSPO_CFG_XOPT_BIT 11
`define CSPO_CFG_CARRY_BIT 10
`endif

// ==== include/cspo_pkg.sv ====
// types shared by the status/option bank
package cspo_pkg;
    typedef enum logic [2:0] {
        cspo_op_none = 3'b000,
        cspo_op_add = 3'b001,
        cspo_op_sub = 3'b010,
        cspo_op_rr = 3'b011,
        cspo_op_rl = 3'b100,
        cspo_op_logic = 3'b101
    } cspo_alu_op_type;
endpackage

// ==== tb/cspo_regs_asserts.sv ====
// concurrent checks on the status/option bank ports
`timescale 1ns/10ps
module cspo_regs_asserts
    import cspo_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic por_i,
    input wire logic file_wr_i,
    input wire logic [4:0] file_addr_i,
    input wire logic opt_wr_i,
    input wire logic [2:0] alu_op_i,
    input wire logic [7:0] alu_a_i,
    input wire logic wdt_clear_i,
    input wire logic sleep_i,
    input wire logic wdt_timeout_i,
    input wire logic prog_mode_i,
    input wire logic [7:0] status_o,
    input wire logic [7:0] option_o,
    input wire logic [11:0] cfg_rdata_o
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    chk_status_ro_bits: assert property (file_wr_i && ce_i && file_addr_i == 5'h03
        && !sleep_i && !wdt_clear_i && !wdt_timeout_i && !por_i |-> ##2 $stable(status_o[4:3]))
        else $error("timeout or power-down bit moved on a status write");
    chk_sleep_flags: assert property (sleep_i && ce_i && !wdt_clear_i && !por_i
        |-> ##2 status_o[4:3] == 2'b10) else $error("sleep flags wrong");
    chk_timeout_flag: assert property (wdt_timeout_i && ce_i && !sleep_i && !wdt_clear_i
        && !por_i |-> ##2 !status_o[4]) else $error("timeout flag not cleared");
    chk_clear_flags: assert property (wdt_clear_i && ce_i |-> ##2 status_o[4:3] == 2'b11)
        else $error("watchdog clear did not set flags");
    chk_por_option: assert property (por_i && ce_i && !opt_wr_i |-> ##2 option_o == 8'hff)
        else $error("option not all ones after power-up");
    chk_rr_carry: assert property (alu_op_i == cspo_op_rr && ce_i
        |-> ##2 status_o[0] == $past(alu_a_i[0], 2)) else $error("rotate right carry wrong");
    chk_rl_carry: assert property (alu_op_i == cspo_op_rl && ce_i
        |-> ##2 status_o[0] == $past(alu_a_i[7], 2)) else $error("rotate left carry wrong");
    chk_cfg_hidden: assert property (!prog_mode_i ##1 (!prog_mode_i && ce_i)
        |-> ##1 cfg_rdata_o == 12'h000)
        else $error("config word visible outside programming mode");

    cover property (sleep_i && ce_i);
    cover property (alu_op_i == cspo_op_rl && ce_i);
    cover property (prog_mode_i && cfg_rdata_o != 12'h000);
endmodule // cspo_regs_asserts

bind cspo_regs cspo_regs_asserts chk (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .por_i(por_i),
    .file_wr_i(file_wr_i), .file_addr_i(file_addr_i), .opt_wr_i(opt_wr_i),
    .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .wdt_clear_i(wdt_clear_i),
    .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i), .prog_mode_i(prog_mode_i),
    .status_o(status_o), .option_o(option_o), .cfg_rdata_o(cfg_rdata_o)
);

// ==== tb/tb.sv ====
// self-checking bench for the status/option bank
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb;
    import cspo_pkg::*;
    logic mclk_i = 0, nrst_i = 0, ce_i = 1, por_i = 0, file_wr_i = 0, opt_wr_i = 0, jump_i = 0;
    logic wdt_clear_i = 0, sleep_i = 0, wdt_timeout_i = 0, counter_pin_i = 0;
    logic prog_mode_i = 0, cfg_wr_i = 0;
    logic [4:0] file_addr_i = '0;
    logic [7:0] file_wdata_i = '0, opt_wdata_i = '0, alu_a_i = '0, alu_b_i = '0;
    logic [2:0] alu_op_i = '0;
    logic [8:0] jump_low_i = '0;
    logic [11:0] cfg_addr_i = '0, cfg_wdata_i = '0, jump_target_o, cfg_rdata_o;
    logic [7:0] status_o, option_o, alu_result_o, free_running_counter_o, device_id_o, c;
    logic addr01_is_counter_o, rollover_irq_o, wdt_tick_o;
    int err_count = 0, check_count = 0, cycles = 0, hits;

    // device id value is arbitrary
    cspo_regs #(.DEVICE_ID(8'h3c)) DUT (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .por_i(por_i),
        .file_wr_i(file_wr_i), .file_addr_i(file_addr_i), .file_wdata_i(file_wdata_i),
        .opt_wr_i(opt_wr_i), .opt_wdata_i(opt_wdata_i), .alu_op_i(alu_op_i),
        .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .wdt_clear_i(wdt_clear_i),
        .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i), .jump_i(jump_i),
        .jump_low_i(jump_low_i), .counter_pin_i(counter_pin_i),
        .prog_mode_i(prog_mode_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
        .cfg_wdata_i(cfg_wdata_i), .status_o(status_o), .option_o(option_o),
        .alu_result_o(alu_result_o), .free_running_counter_o(free_running_counter_o),
        .addr01_is_counter_o(addr01_is_counter_o), .rollover_irq_o(rollover_irq_o),
        .wdt_tick_o(wdt_tick_o), .jump_target_o(jump_target_o),
        .cfg_rdata_o(cfg_rdata_o), .device_id_o(device_id_o)
    );

    always #25 mclk_i = ~mclk_i;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic step(input int n = 1);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // outputs lag the internal state by one edge, so judge two edges after the request
    task automatic strobe;
        step();
        {file_wr_i, opt_wr_i, cfg_wr_i, jump_i, por_i, sleep_i, wdt_clear_i, wdt_timeout_i} = '0;
        alu_op_i = 3'h0;
        step();
    endtask

    task automatic opt(input logic [7:0] v);
        opt_wdata_i = v;
        opt_wr_i = 1;
        strobe();
    endtask

    // the result register follows the operand every cycle, so judge it one edge on
    task automatic alu(input logic [2:0] op, input logic [7:0] a, b, res, fl, m);
        alu_op_i = op;
        alu_a_i = a;
        alu_b_i = b;
        step();
        `CHK(alu_result_o, res);
        alu_op_i = 3'h0;
        step();
        `CHK(status_o & m, fl);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        `CHK(status_o, 8'h18);
        `CHK(option_o, 8'hff);
        `CHK(addr01_is_counter_o, 1'b1);
        `CHK(device_id_o, 8'h3c);
        $display("test reset done");
    endtask

    task automatic t_status;
        file_wr_i = 1;
        file_addr_i = 5'h03;
        file_wdata_i = 8'h67;
        strobe();
        `CHK(status_o, 8'h7f);
        file_wr_i = 1;
        file_wdata_i = status_o & ~8'h01;
        strobe();
        `CHK(status_o, 8'h7e);
        file_wr_i = 1;
        file_wdata_i = 8'h60;
        alu_op_i = 3'h1;
        alu_a_i = 8'hff;
        alu_b_i = 8'h01;
        strobe();
        `CHK(status_o, 8'h7f);
        jump_i = 1;
        jump_low_i = 9'h1a5;
        strobe();
        `CHK(jump_target_o, 12'h7a5);
        $display("test status done");
    endtask

    task automatic t_alu;
        alu(3'h1, 8'h0f, 8'h01, 8'h10, 8'h02, 8'h07);
        alu(3'h1, 8'hff, 8'h01, 8'h00, 8'h07, 8'h07);
        alu(3'h2, 8'h05, 8'h05, 8'h00, 8'h07, 8'h07);
        alu(3'h3, 8'h01, 8'h00, 8'h80, 8'h01, 8'h01);
        alu(3'h4, 8'h40, 8'h00, 8'h81, 8'h00, 8'h01);
        alu(3'h3, 8'h02, 8'h00, 8'h01, 8'h00, 8'h01);
        alu(3'h5, 8'hf0, 8'h0f, 8'h00, 8'h04, 8'h04);
        $display("test alu done");
    endtask

    task automatic t_cfg;
        opt(8'h00);
        `CHK(option_o, 8'hc0);
        cfg_addr_i = 12'hfff;
        cfg_wdata_i = 12'h3ff;
        cfg_wr_i = 1;
        strobe();
        prog_mode_i = 1;
        step(3);
        `CHK(cfg_rdata_o, 12'hfff);
        cfg_wr_i = 1;
        strobe();
        step();
        `CHK(cfg_rdata_o, 12'h3ff);
        prog_mode_i = 0;
        opt(8'h00);
        `CHK(option_o, 8'h00);
        `CHK(addr01_is_counter_o, 1'b0);
        alu(3'h2, 8'h05, 8'h05, 8'hff, 8'h00, 8'h07);
        alu(3'h1, 8'hff, 8'h01, 8'h00, 8'h07, 8'h07);
        alu(3'h1, 8'h01, 8'h01, 8'h03, 8'h00, 8'h07);
        $display("test config done");
    endtask

    task automatic t_counter;
        opt(8'h08);
        c = free_running_counter_o;
        step();
        `CHK(free_running_counter_o - c, 8'd1);
        hits = 0;
        while (!rollover_irq_o && hits < 300) begin
            step();
            hits++;
        end
        `CHK(rollover_irq_o, 1'b1);
        opt(8'h48);
        hits = 0;
        repeat (300) begin
            step();
            if (rollover_irq_o === 1'b1) hits++;
        end
        `CHK(hits, 0);
        for (int n = 0; n < 3; n++) begin
            opt({5'h00, n[2:0]});
            c = free_running_counter_o;
            step(10 << (n + 1));
            `CHK(free_running_counter_o - c, 8'd10);
        end
        opt(8'h0b);
        hits = 0;
        repeat (80) begin
            step();
            if (wdt_tick_o === 1'b1) hits++;
        end
        `CHK(hits, 10);
        ce_i = 0;
        c = free_running_counter_o;
        step(5);
        `CHK(free_running_counter_o - c, 8'd0);
        ce_i = 1;
        for (int s = 0; s < 2; s++) begin
            opt(s ? 8'h38 : 8'h28);
            c = free_running_counter_o;
            counter_pin_i = 1;
            step(6);
            `CHK(free_running_counter_o - c, s ? 8'd0 : 8'd1);
            counter_pin_i = 0;
            step(6);
            `CHK(free_running_counter_o - c, 8'd1);
        end
        $display("test counter done");
    endtask

    task automatic t_flags;
        sleep_i = 1;
        strobe();
        `CHK(status_o[4:3], 2'b10);
        wdt_timeout_i = 1;
        strobe();
        `CHK(status_o[4:3], 2'b00);
        por_i = 1;
        strobe();
        `CHK(status_o[4:3], 2'b11);
        `CHK(option_o, 8'hff);
        sleep_i = 1;
        strobe();
        wdt_clear_i = 1;
        strobe();
        `CHK(status_o[4:3], 2'b11);
        $display("test flags done");
    endtask

    initial begin
        step(6);
        nrst_i = 1;
        step();
        t_reset();
        t_status();
        t_alu();
        t_cfg();
        t_counter();
        t_flags();
        wrap_up();
    end
endmodule // tb
